// ===== design/frontend_cfg_pkg.sv
// package: register map, field layout, reset values and timing for the front-end configuration block
package frontend_cfg_pkg;

	// ***************************************************************
	// register bus and address map
	// ***************************************************************
	localparam int          ADDR_W             = 32;
	localparam int          DATA_W             = 8;
	localparam logic [31:0] SECOND_DEMOD_CONFIG_ADDR   = 32'h4000_0521;
	localparam logic [31:0] AUX_CONVERTER_CONFIG_ADDR  = 32'h4000_0522;
	localparam logic [31:0] DEMOD_PAIR_RESET_CLOCK_ADDR = 32'h4000_0524;
	localparam logic [31:0] AUX_CONVERTER_RESET_CLOCK_ADDR = 32'h4000_0526;
	localparam logic [31:0] FIRST_GAIN_STAGE_CONFIG_ADDR  = 32'h4000_0527;
	localparam logic [31:0] SECOND_GAIN_STAGE_CONFIG_ADDR = 32'h4000_0528;

	// ***************************************************************
	// field positions
	// ***************************************************************
	localparam int CHAN_ENABLE_BIT     = 0;
	localparam int CHAN_RATE_BIT       = 2;
	localparam int AUX_DECIM_BIT       = 0;
	localparam int MOD_RESET_BIT       = 0;
	localparam int CLK_RESET_BIT       = 1;
	localparam int CLOCK_ENABLE_BIT    = 3;
	localparam int GAIN_LSB            = 0;
	localparam int GAIN_MSB            = 1;
	localparam int SINGLE_ENDED_BIT    = 6;
	localparam int INVERT_BIT          = 7;

	// ***************************************************************
	// writable masks (reserved bits read zero) and reset values
	// ***************************************************************
	localparam logic [7:0] CHAN_CFG_MASK   = 8'h05;
	localparam logic [7:0] AUX_CFG_MASK    = 8'h01;
	localparam logic [7:0] RESET_CTL_MASK  = 8'h7f;
	localparam logic [7:0] STAGE_CFG_MASK  = 8'hc3;
	localparam logic [7:0] CHAN_CFG_RST    = 8'h04;
	localparam logic [7:0] AUX_CFG_RST     = 8'h00;
	localparam logic [7:0] RESET_CTL_RST   = 8'h03;
	localparam logic [7:0] STAGE_CFG_RST   = 8'h00;
	localparam logic [7:0] RDATA_RST       = 8'h00;

	// ***************************************************************
	// gain selects, one-hot towards the analog stage
	// ***************************************************************
	localparam logic [1:0] GAIN_CODE_1P00 = 2'h0;
	localparam logic [1:0] GAIN_CODE_1P33 = 2'h1;
	localparam logic [1:0] GAIN_CODE_1P67 = 2'h2;
	localparam logic [1:0] GAIN_CODE_2P00 = 2'h3;
	localparam logic [3:0] GAIN_SEL_1P00  = 4'h1;
	localparam logic [3:0] GAIN_SEL_1P33  = 4'h2;
	localparam logic [3:0] GAIN_SEL_1P67  = 4'h4;
	localparam logic [3:0] GAIN_SEL_2P00  = 4'h8;

	// ***************************************************************
	// sample timing
	// ***************************************************************
	localparam int CLK_MHZ          = 200;
	localparam int SAMPLE_LONG_US   = 256;
	localparam int SAMPLE_SHORT_US  = 128;
	localparam int SAMPLE_LONG_CYC  = SAMPLE_LONG_US * CLK_MHZ;
	localparam int SAMPLE_SHORT_CYC = SAMPLE_SHORT_US * CLK_MHZ;
	localparam int TIMER_W          = 16;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} bus_req_type;

	typedef struct packed {
		logic [3:0] gain_sel;
		logic       single_ended;
		logic       invert;
	} gain_stage_ctrl_type;

	typedef struct packed {
		logic [7:0] chan_cfg;
		logic [7:0] aux_cfg;
		logic [7:0] pair_ctl;
		logic [7:0] aux_ctl;
		logic [7:0] first_gain_stage_config;
		logic [7:0] second_gain_stage_config;
		logic [3:0] first_stage_gain_select_sel;
		logic [3:0] second_stage_gain_select_sel;
		logic [7:0] rdata;
		logic       rd_valid;
	} cfg_state_type;

	typedef struct packed {
		logic [TIMER_W-1:0] count;
		logic               rate_q;
		logic               tick;
	} timer_state_type;

	// gain code to one-hot select
	function automatic logic [3:0] gain_decode(input logic [1:0] code);
		logic [3:0] sel;
		sel = GAIN_SEL_1P00;
		unique case (code)
			GAIN_CODE_1P00: sel = GAIN_SEL_1P00;
			GAIN_CODE_1P33: sel = GAIN_SEL_1P33;
			GAIN_CODE_1P67: sel = GAIN_SEL_1P67;
			GAIN_CODE_2P00: sel = GAIN_SEL_2P00;
		endcase
		return sel;
	endfunction

endpackage

// ===== design/sample_rate_timer.sv
// module: output-sample strobe generator for the second demodulator channel
`timescale 1ns/100ps
module sample_rate_timer
	import frontend_cfg_pkg::*;
#(
	parameter int LONG_CYC  = SAMPLE_LONG_CYC,
	parameter int SHORT_CYC = SAMPLE_SHORT_CYC
)
(
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic i_run,
	input  wire logic i_rate_long,
	output logic      o_tick
);

	localparam logic [TIMER_W-1:0] LONG_LAST  = TIMER_W'(LONG_CYC - 1);
	localparam logic [TIMER_W-1:0] SHORT_LAST = TIMER_W'(SHORT_CYC - 1);

	timer_state_type state_r;
	timer_state_type state_nxt;
	logic [TIMER_W-1:0] last_cnt;

	// ***************************************************************
	// period counter
	// ***************************************************************

	// restart on stop or rate change so the first sample after a change is a full period
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.tick = 1'b0;
		state_nxt.rate_q = i_rate_long;
		last_cnt = i_rate_long ? LONG_LAST : SHORT_LAST;
		if (!i_run || (i_rate_long != state_r.rate_q))
			state_nxt.count = '0;
		else if (state_r.count == last_cnt)
		begin
			state_nxt.count = '0;
			state_nxt.tick = 1'b1;
		end
		else
			state_nxt.count = state_r.count + 1'b1;
	end

	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
			state_r <= '0;
		else
			state_r <= state_nxt;
	end

	assign o_tick = state_r.tick;

	// ***************************************************************
	// checks
	// ***************************************************************

	// gap since the last strobe, only for the assertion
	logic [TIMER_W-1:0] gap_r;
	logic               seen_r;
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			gap_r <= '0;
			seen_r <= 1'b0;
		end
		else if (!i_run || (i_rate_long != state_r.rate_q))
		begin
			gap_r <= '0;
			seen_r <= 1'b0;
		end
		else if (state_r.tick)
		begin
			gap_r <= '0;
			seen_r <= 1'b1;
		end
		else
			gap_r <= gap_r + 1'b1;
	end

	sample_period_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		(state_r.tick && seen_r) |-> (gap_r == (state_r.rate_q ? LONG_LAST : SHORT_LAST)))
		else $error("sample strobe spacing wrong");

	tick_needs_run_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
		state_r.tick |-> $past(i_run))
		else $error("sample strobe while channel stopped");

	long_tick_c: cover property (@(posedge i_clk) disable iff (!i_reset_n) state_r.tick && seen_r && state_r.rate_q);
	short_tick_c: cover property (@(posedge i_clk) disable iff (!i_reset_n) state_r.tick && seen_r && !state_r.rate_q);

endmodule

// ===== design/demod_adc_frontend_config.sv
// module: configuration registers for the demodulator pair, auxiliary converter and input gain stages
// What this block does
// - channel-two enable bit enables second demodulator
// - rate bit: 256 us or 128 us samples
// - aux decimator runs only while enable set
// - shared bit holds both modulators in reset
// - shared bit holds both modulator clocks reset
// - demod interfaces and decimator clocks gated by bit
// - aux modulator held in reset by bit
// - aux modulator clocks held reset by bit
// - aux interfaces and decimator clocks gated by bit
// - gain codes: 1, 1.33, 1.67, 2 V/V
// - first stage single-ended when bit set
// - second stage single-ended when bit set
// - first stage output inverted when bit set
// - second stage output inverted when bit set
`timescale 1ns/100ps
module demod_adc_frontend_config
	import frontend_cfg_pkg::*;
#(
	parameter int LONG_CYC  = SAMPLE_LONG_CYC,
	parameter int SHORT_CYC = SAMPLE_SHORT_CYC
)
(
	input  wire logic          i_clk,
	input  wire logic          i_reset_n,
	input  wire bus_req_type   i_bus,
	output logic [DATA_W-1:0]  o_rdata,
	output logic               o_rd_valid,
	output logic               o_second_channel_enable,
	output logic               o_second_channel_rate_select,
	output logic               o_second_sample_tick,
	output logic               o_aux_decimator_enable,
	output logic               o_demod_modulator_reset,
	output logic               o_demod_modulator_clock_reset,
	output logic               o_demodulator_clock_enable,
	output logic               o_aux_modulator_reset,
	output logic               o_aux_modulator_clock_reset,
	output logic               o_aux_clock_enable,
	output gain_stage_ctrl_type o_first_stage,
	output gain_stage_ctrl_type o_second_stage
);

	cfg_state_type state_r;
	cfg_state_type state_nxt;
	logic          chan_run;

	// ***************************************************************
	// address decode
	// ***************************************************************

	// decode one byte address per register
	logic sel_chan;
	logic sel_aux;
	logic sel_pair;
	logic sel_auxctl;
	logic sel_s1;
	logic sel_s2;
	assign sel_chan   = (i_bus.addr == SECOND_DEMOD_CONFIG_ADDR);
	assign sel_aux    = (i_bus.addr == AUX_CONVERTER_CONFIG_ADDR);
	assign sel_pair   = (i_bus.addr == DEMOD_PAIR_RESET_CLOCK_ADDR);
	assign sel_auxctl = (i_bus.addr == AUX_CONVERTER_RESET_CLOCK_ADDR);
	assign sel_s1     = (i_bus.addr == FIRST_GAIN_STAGE_CONFIG_ADDR);
	assign sel_s2     = (i_bus.addr == SECOND_GAIN_STAGE_CONFIG_ADDR);

	// ***************************************************************
	// register file
	// ***************************************************************

	// writes mask reserved bits; write-zero bits are stored, software keeps them clear
	always_comb
	begin
		state_nxt = state_r;
		state_nxt.rd_valid = i_bus.rd;
		if (i_bus.wr)
		begin
			if (sel_chan)
				state_nxt.chan_cfg = i_bus.wdata & CHAN_CFG_MASK;
			if (sel_aux)
				state_nxt.aux_cfg = i_bus.wdata & AUX_CFG_MASK;
			if (sel_pair)
				state_nxt.pair_ctl = i_bus.wdata & RESET_CTL_MASK;
			if (sel_auxctl)
				state_nxt.aux_ctl = i_bus.wdata & RESET_CTL_MASK;
			if (sel_s1)
				state_nxt.first_gain_stage_config = i_bus.wdata & STAGE_CFG_MASK;
			if (sel_s2)
				state_nxt.second_gain_stage_config = i_bus.wdata & STAGE_CFG_MASK;
		end
		// one-hot gain select follows the stored code
		state_nxt.first_stage_gain_select_sel = gain_decode(state_nxt.first_gain_stage_config[GAIN_MSB:GAIN_LSB]);
		state_nxt.second_stage_gain_select_sel = gain_decode(state_nxt.second_gain_stage_config[GAIN_MSB:GAIN_LSB]);
		// read returns the value held before a same-cycle write; unmapped reads give zero
		state_nxt.rdata = RDATA_RST;
		if (i_bus.rd)
		begin
			if (sel_chan)
				state_nxt.rdata = state_r.chan_cfg;
			else if (sel_aux)
				state_nxt.rdata = state_r.aux_cfg;
			else if (sel_pair)
				state_nxt.rdata = state_r.pair_ctl;
			else if (sel_auxctl)
				state_nxt.rdata = state_r.aux_ctl;
			else if (sel_s1)
				state_nxt.rdata = state_r.first_gain_stage_config;
			else if (sel_s2)
				state_nxt.rdata = state_r.second_gain_stage_config;
		end
	end

	// reset values put both modulators and their clocks in reset
	always_ff @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			state_r.chan_cfg    <= CHAN_CFG_RST;
			state_r.aux_cfg     <= AUX_CFG_RST;
			state_r.pair_ctl    <= RESET_CTL_RST;
			state_r.aux_ctl     <= RESET_CTL_RST;
			state_r.first_gain_stage_config      <= STAGE_CFG_RST;
			state_r.second_gain_stage_config      <= STAGE_CFG_RST;
			state_r.first_stage_gain_select_sel <= GAIN_SEL_1P00;
			state_r.second_stage_gain_select_sel <= GAIN_SEL_1P00;
			state_r.rdata       <= RDATA_RST;
			state_r.rd_valid    <= 1'b0;
		end
		else
			state_r <= state_nxt;
	end

	// ***************************************************************
	// outputs to the analog side
	// ***************************************************************

	// all straight from the stored bits
	assign o_rdata                       = state_r.rdata;
	assign o_rd_valid                    = state_r.rd_valid;
	assign o_second_channel_enable       = state_r.chan_cfg[CHAN_ENABLE_BIT];
	assign o_second_channel_rate_select  = state_r.chan_cfg[CHAN_RATE_BIT];
	assign o_aux_decimator_enable        = state_r.aux_cfg[AUX_DECIM_BIT];
	assign o_demod_modulator_reset       = state_r.pair_ctl[MOD_RESET_BIT];
	assign o_demod_modulator_clock_reset = state_r.pair_ctl[CLK_RESET_BIT];
	assign o_demodulator_clock_enable    = state_r.pair_ctl[CLOCK_ENABLE_BIT];
	assign o_aux_modulator_reset         = state_r.aux_ctl[MOD_RESET_BIT];
	assign o_aux_modulator_clock_reset   = state_r.aux_ctl[CLK_RESET_BIT];
	assign o_aux_clock_enable            = state_r.aux_ctl[CLOCK_ENABLE_BIT];
	assign o_first_stage  = {state_r.first_stage_gain_select_sel, state_r.first_gain_stage_config[SINGLE_ENDED_BIT], state_r.first_gain_stage_config[INVERT_BIT]};
	assign o_second_stage = {state_r.second_stage_gain_select_sel, state_r.second_gain_stage_config[SINGLE_ENDED_BIT], state_r.second_gain_stage_config[INVERT_BIT]};

	// ***************************************************************
	// sample strobe
	// ***************************************************************

	// no samples while the modulators or their clocks sit in reset, or clocks are gated
	assign chan_run = state_r.chan_cfg[CHAN_ENABLE_BIT]
		& state_r.pair_ctl[CLOCK_ENABLE_BIT]
		& ~state_r.pair_ctl[MOD_RESET_BIT]
		& ~state_r.pair_ctl[CLK_RESET_BIT];

	sample_rate_timer #(
		.LONG_CYC  (LONG_CYC),
		.SHORT_CYC (SHORT_CYC)
	) u_rate_timer (
		.i_clk       (i_clk),
		.i_reset_n   (i_reset_n),
		.i_run       (chan_run),
		.i_rate_long (state_r.chan_cfg[CHAN_RATE_BIT]),
		.o_tick      (o_second_sample_tick)
	);

	// ***************************************************************
	// checks
	// ***************************************************************

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	chan_enable_wr_a: assert property (
		(i_bus.wr && sel_chan) |=> (o_second_channel_enable == $past(i_bus.wdata[CHAN_ENABLE_BIT])))
		else $error("channel enable did not follow write");

	chan_rate_wr_a: assert property (
		(i_bus.wr && sel_chan) |=> (o_second_channel_rate_select == $past(i_bus.wdata[CHAN_RATE_BIT])))
		else $error("rate select did not follow write");

	aux_decim_wr_a: assert property (
		(i_bus.wr && sel_aux) |=> (o_aux_decimator_enable == $past(i_bus.wdata[AUX_DECIM_BIT])))
		else $error("aux decimator enable did not follow write");

	pair_reset_wr_a: assert property (
		(i_bus.wr && sel_pair) |=> (o_demod_modulator_reset == $past(i_bus.wdata[MOD_RESET_BIT])
			&& o_demod_modulator_clock_reset == $past(i_bus.wdata[CLK_RESET_BIT])))
		else $error("pair modulator resets did not follow write");

	pair_hold_a: assert property (
		!(i_bus.wr && sel_pair) |=> ($stable(o_demod_modulator_clock_reset) && $stable(o_demodulator_clock_enable)))
		else $error("pair control changed without a write");

	samples_gated_a: assert property (
		(!o_demodulator_clock_enable || o_demod_modulator_reset) [*2] |-> !o_second_sample_tick)
		else $error("sample strobe while pair clocks gated or in reset");

	aux_ctl_wr_a: assert property (
		(i_bus.wr && sel_auxctl) |=> (o_aux_modulator_reset == $past(i_bus.wdata[MOD_RESET_BIT])
			&& o_aux_modulator_clock_reset == $past(i_bus.wdata[CLK_RESET_BIT])
			&& o_aux_clock_enable == $past(i_bus.wdata[CLOCK_ENABLE_BIT])))
		else $error("aux control did not follow write");

	aux_ctl_hold_a: assert property (
		!(i_bus.wr && sel_auxctl) |=> ($stable(o_aux_modulator_clock_reset) && $stable(o_aux_clock_enable)))
		else $error("aux control changed without a write");

	gain_decode_a: assert property (
		(i_bus.wr && sel_s1 && i_bus.wdata[GAIN_MSB:GAIN_LSB] == GAIN_CODE_1P67)
		|=> (o_first_stage.gain_sel == GAIN_SEL_1P67) && $onehot(o_second_stage.gain_sel))
		else $error("gain select decode wrong");

	stage_one_wr_a: assert property (
		(i_bus.wr && sel_s1) |=> (o_first_stage.single_ended == $past(i_bus.wdata[SINGLE_ENDED_BIT])
			&& o_first_stage.invert == $past(i_bus.wdata[INVERT_BIT])))
		else $error("first stage mode did not follow write");

	stage_two_wr_a: assert property (
		(i_bus.wr && sel_s2) |=> (o_second_stage.single_ended == $past(i_bus.wdata[SINGLE_ENDED_BIT])
			&& o_second_stage.invert == $past(i_bus.wdata[INVERT_BIT])
			&& o_second_stage.gain_sel == (GAIN_SEL_1P00 << $past(i_bus.wdata[GAIN_MSB:GAIN_LSB]))))
		else $error("second stage config did not follow write");

	reserved_zero_a: assert property (
		(i_bus.rd && (sel_chan || sel_aux || sel_s1)) |=>
			o_rd_valid && ((o_rdata & ~(CHAN_CFG_MASK | STAGE_CFG_MASK)) == RDATA_RST))
		else $error("reserved bits read nonzero");

	unmapped_zero_a: assert property (
		(i_bus.rd && !(sel_chan || sel_aux || sel_pair || sel_auxctl || sel_s1 || sel_s2))
		|=> (o_rd_valid && o_rdata == RDATA_RST))
		else $error("unmapped read not zero");

	// ***************************************************************
	// hold and readback checks
	// ***************************************************************

	// a register moves only on a write to its own address
	chan_hold_a: assert property (
		!(i_bus.wr && sel_chan) |=> $stable(state_r.chan_cfg))
		else $error("channel config moved without write");

	aux_hold_a: assert property (
		!(i_bus.wr && sel_aux) |=> $stable(o_aux_decimator_enable))
		else $error("aux decimator moved without write");

	pair_mod_hold_a: assert property (
		!(i_bus.wr && sel_pair) |=> $stable(o_demod_modulator_reset))
		else $error("pair reset moved without write");

	aux_mod_hold_a: assert property (
		!(i_bus.wr && sel_auxctl) |=> $stable(o_aux_modulator_reset))
		else $error("aux reset moved without write");

	stage_one_hold_a: assert property (
		!(i_bus.wr && sel_s1) |=> $stable(o_first_stage))
		else $error("first stage moved without write");

	stage_two_hold_a: assert property (
		!(i_bus.wr && sel_s2) |=> $stable(o_second_stage))
		else $error("second stage moved without write");

	// reserved bits of each register read zero
	chan_read_a: assert property (
		(i_bus.rd && sel_chan) |=> ((o_rdata & ~CHAN_CFG_MASK) == RDATA_RST))
		else $error("channel reserved bits nonzero");

	aux_read_a: assert property (
		(i_bus.rd && sel_aux) |=> ((o_rdata & ~AUX_CFG_MASK) == RDATA_RST))
		else $error("aux reserved bits nonzero");

	ctl_read_a: assert property (
		(i_bus.rd && (sel_pair || sel_auxctl)) |=> ((o_rdata & ~RESET_CTL_MASK) == RDATA_RST))
		else $error("control bit 7 nonzero");

	stage_read_a: assert property (
		(i_bus.rd && (sel_s1 || sel_s2)) |=> ((o_rdata & ~STAGE_CFG_MASK) == RDATA_RST))
		else $error("stage reserved bits nonzero");

	// the timer lags one cycle, so two quiet cycles are needed
	chan_off_quiet_a: assert property (
		(!o_second_channel_enable) [*2] |-> !o_second_sample_tick)
		else $error("strobe while channel disabled");

	clk_reset_quiet_a: assert property (
		o_demod_modulator_clock_reset [*2] |-> !o_second_sample_tick)
		else $error("strobe while clocks in reset");

	// read answer is one pulse; data idles at zero
	rd_idle_a: assert property (
		!i_bus.rd |=> (!o_rd_valid && o_rdata == RDATA_RST))
		else $error("read answer without read");

	// scenarios worth seeing
	pair_release_c: cover property (o_demod_modulator_reset ##1 !o_demod_modulator_reset);
	stage_invert_c: cover property (o_first_stage.invert && o_second_stage.single_ended);
	sample_run_c: cover property (o_second_sample_tick);

endmodule

// ===== verif/analog_frontend_model.sv
// model of the analog side: gain stages and delta-sigma modulators driven by the config outputs
`timescale 1ns/100ps
module analog_frontend_model
	import frontend_cfg_pkg::*;
(
	input  wire gain_stage_ctrl_type i_first_stage,
	input  wire gain_stage_ctrl_type i_second_stage,
	input  wire logic                i_demod_mod_reset,
	input  wire logic                i_demod_clk_reset,
	input  wire logic                i_demod_clk_en,
	input  wire logic                i_aux_mod_reset,
	input  wire logic                i_aux_clk_reset,
	input  wire logic                i_aux_clk_en,
	input  wire logic                i_aux_dec_en,
	output logic signed [8:0]        o_first_gain_centi,
	output logic signed [8:0]        o_second_gain_centi,
	output logic                     o_demod_running,
	output logic                     o_aux_running
);
	// stage gain in hundredths; a select that is not one-hot leaves the stage dead
	function automatic logic signed [8:0] stage_gain(input gain_stage_ctrl_type s);
		logic signed [8:0] g;
		case (s.gain_sel)
			4'h1:    g = 9'sh064;
			4'h2:    g = 9'sh085;
			4'h4:    g = 9'sh0a7;
			4'h8:    g = 9'sh0c8;
			default: g = 9'sh000;
		endcase
		return s.invert ? -g : g;
	endfunction

	// signed gain of each stage, inversion folded into the sign
	assign o_first_gain_centi  = stage_gain(i_first_stage);
	assign o_second_gain_centi = stage_gain(i_second_stage);
	// modulators convert only out of reset with their clocks released and enabled
	assign o_demod_running = !i_demod_mod_reset && !i_demod_clk_reset && i_demod_clk_en;
	assign o_aux_running   = !i_aux_mod_reset && !i_aux_clk_reset && i_aux_clk_en && i_aux_dec_en;
endmodule

// ===== verif/demod_adc_frontend_config_tb.sv
// testbench: register access, field decode and sample strobe of the front-end configuration block
`timescale 1ns/100ps
module demod_adc_frontend_config_tb;
	import frontend_cfg_pkg::*;
	localparam int LONG_T  = 16;
	localparam int SHORT_T = 8;

	logic                i_clk;
	logic                i_reset_n;
	bus_req_type         bus;
	logic [DATA_W-1:0]   rdata;
	logic                rd_valid, ch_en, ch_rate, tick, aux_dec;
	logic                dm_rst, dm_clk_rst, dm_clk_en, ax_rst, ax_clk_rst, ax_clk_en;
	gain_stage_ctrl_type st1, st2;
	logic signed [8:0]   g1, g2;
	logic                dm_run, ax_run;
	int                  err_count = 0;
	int                  comparisons = 0;
	logic [31:0]         addrs [6] = '{32'h4000_0521, 32'h4000_0522, 32'h4000_0524,
		32'h4000_0526, 32'h4000_0527, 32'h4000_0528};
	logic [7:0]          rsts  [6] = '{8'h04, 8'h00, 8'h03, 8'h03, 8'h00, 8'h00};
	logic [7:0]          masks [6] = '{8'h05, 8'h01, 8'h7f, 8'h7f, 8'hc3, 8'hc3};
	// write-zero bits kept clear, reserved bit 7 set to show it is dropped
	logic [7:0]          pat [2][6] = '{'{8'hff, 8'hff, 8'h8b, 8'h8b, 8'hff, 8'hff},
		'{8'hfa, 8'hfe, 8'h80, 8'h80, 8'h3c, 8'h3c}};
	logic [7:0]          shadow [6];
	logic [1:0]          g;

	// ***************************************************************
	// clock, design and analog model
	// ***************************************************************
	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	demod_adc_frontend_config #(.LONG_CYC(LONG_T), .SHORT_CYC(SHORT_T)) demod_adc_frontend_config_i (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .i_bus(bus), .o_rdata(rdata), .o_rd_valid(rd_valid),
		.o_second_channel_enable(ch_en), .o_second_channel_rate_select(ch_rate),
		.o_second_sample_tick(tick), .o_aux_decimator_enable(aux_dec),
		.o_demod_modulator_reset(dm_rst), .o_demod_modulator_clock_reset(dm_clk_rst),
		.o_demodulator_clock_enable(dm_clk_en), .o_aux_modulator_reset(ax_rst),
		.o_aux_modulator_clock_reset(ax_clk_rst), .o_aux_clock_enable(ax_clk_en),
		.o_first_stage(st1), .o_second_stage(st2));

	analog_frontend_model analog_frontend_model_i (
		.i_first_stage(st1), .i_second_stage(st2), .i_demod_mod_reset(dm_rst),
		.i_demod_clk_reset(dm_clk_rst), .i_demod_clk_en(dm_clk_en), .i_aux_mod_reset(ax_rst),
		.i_aux_clk_reset(ax_clk_rst), .i_aux_clk_en(ax_clk_en), .i_aux_dec_en(aux_dec),
		.o_first_gain_centi(g1), .o_second_gain_centi(g2), .o_demod_running(dm_run),
		.o_aux_running(ax_run));

	// ***************************************************************
	// tasks
	// ***************************************************************
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one-cycle write strobe; the shadow keeps only the stored bits
	task automatic wr(input logic [31:0] a, input logic [7:0] d);
		@(negedge i_clk);
		bus.wr = 1'b1;
		bus.addr = a;
		bus.wdata = d;
		@(negedge i_clk);
		bus.wr = 1'b0;
		for (int i = 0; i < 6; i++)
			if (a == addrs[i])
				shadow[i] = d & masks[i];
	endtask

	// read answer lands just after the taking edge and stands one cycle
	task automatic rd(input logic [31:0] a, input logic [7:0] e);
		@(negedge i_clk);
		bus.rd = 1'b1;
		bus.addr = a;
		@(posedge i_clk);
		#1;
		check("rd_valid", rd_valid, 1'b1);
		check("rdata", rdata, e);
		@(negedge i_clk);
		bus.rd = 1'b0;
	endtask

	// own gain figures in hundredths, never the design's decode
	function automatic logic signed [8:0] gain_exp(input logic [1:0] code, input logic inv);
		logic signed [8:0] c [4];
		c = '{9'sh064, 9'sh085, 9'sh0a7, 9'sh0c8};
		return inv ? -c[code] : c[code];
	endfunction

	// read every register back, then compare every output except the sample strobe with the shadow
	task automatic verify_all();
		logic signed [8:0] e1, e2;
		for (int i = 0; i < 6; i++)
			rd(addrs[i], shadow[i]);
		e1 = gain_exp(shadow[4][1:0], shadow[4][7]);
		e2 = gain_exp(shadow[5][1:0], shadow[5][7]);
		check("ch_en", ch_en, shadow[0][0]);
		check("ch_rate", ch_rate, shadow[0][2]);
		check("aux_dec", aux_dec, shadow[1][0]);
		check("dm_rst", dm_rst, shadow[2][0]);
		check("dm_clk_rst", dm_clk_rst, shadow[2][1]);
		check("dm_clk_en", dm_clk_en, shadow[2][3]);
		check("ax_rst", ax_rst, shadow[3][0]);
		check("ax_clk_rst", ax_clk_rst, shadow[3][1]);
		check("ax_clk_en", ax_clk_en, shadow[3][3]);
		check("dm_run", dm_run, !shadow[2][0] && !shadow[2][1] && shadow[2][3]);
		check("ax_run", ax_run, !shadow[3][0] && !shadow[3][1] && shadow[3][3] && shadow[1][0]);
		check("first_stage_gain_select", st1.gain_sel, 4'h1 << shadow[4][1:0]);
		check("second_stage_gain_select", st2.gain_sel, 4'h1 << shadow[5][1:0]);
		check("s1_centi", g1, e1);
		check("s2_centi", g2, e2);
		check("s1_se", st1.single_ended, shadow[4][6]);
		check("s2_se", st2.single_ended, shadow[5][6]);
		check("first_stage_invert", st1.invert, shadow[4][7]);
		check("second_stage_invert", st2.invert, shadow[5][7]);
	endtask

	// wait for a tick, then count the cycles up to the next one
	task automatic period(input int exp);
		int n;
		n = 0;
		while (tick !== 1'b1 && n < 100)
		begin
			@(posedge i_clk);
			#1;
			n++;
		end
		n = 0;
		do
		begin
			@(posedge i_clk);
			#1;
			n++;
		end while (tick !== 1'b1 && n < 100);
		check("tick_period", 16'(n), 16'(exp));
	endtask

	// no strobe may appear while the channel is stopped
	task automatic quiet(input int cycles);
		int n;
		n = 0;
		repeat (cycles)
		begin
			@(posedge i_clk);
			#1;
			if (tick === 1'b1)
				n++;
		end
		check("ticks_while_off", 16'(n), 16'h0000);
	endtask

	// ***************************************************************
	// main sequence and watchdog
	// ***************************************************************
	initial
	begin
		i_reset_n = 1'b0;
		bus = '0;
		shadow = rsts;
		repeat (16) @(posedge i_clk);
		@(negedge i_clk);
		i_reset_n = 1'b1;
		verify_all();
		// reserved bits set and defined bits swept both ways
		for (int p = 0; p < 2; p++)
		begin
			for (int i = 0; i < 6; i++)
				wr(addrs[i], pat[p][i]);
			verify_all();
		end
		// every gain code on both stages; mode and inversion differ between stages only for codes 0 and 3
		for (int k = 0; k < 4; k++)
		begin
			g = k[1:0];
			wr(addrs[4], {g[0], g[1], 4'hf, g});
			wr(addrs[5], {~g[1], ~g[0], 4'h0, ~g});
			verify_all();
		end
		// unmapped places ignore writes and read zero
		wr(32'h4000_0523, 8'hff);
		wr(32'h4000_0520, 8'hff);
		rd(32'h4000_0523, 8'h00);
		rd(32'h4000_0529, 8'h00);
		// write and read in one cycle: the read returns the old value
		@(negedge i_clk);
		bus.wr = 1'b1;
		bus.rd = 1'b1;
		bus.addr = addrs[1];
		bus.wdata = ~shadow[1];
		@(posedge i_clk);
		#1;
		check("rdata_old", rdata, shadow[1]);
		@(negedge i_clk);
		bus.wr = 1'b0;
		bus.rd = 1'b0;
		shadow[1] = ~shadow[1] & masks[1];
		verify_all();
		// sample strobe at both rates, then stopped by enable and by modulator reset
		wr(addrs[2], 8'h08);
		wr(addrs[0], 8'h05);
		period(LONG_T);
		wr(addrs[0], 8'h01);
		period(SHORT_T);
		wr(addrs[0], 8'h00);
		quiet(3 * LONG_T);
		wr(addrs[0], 8'h01);
		wr(addrs[2], 8'h09);
		quiet(3 * LONG_T);
		verify_all();
		test_done();
	end

	// the whole run needs a few hundred cycles; this cuts a hang short
	initial
	begin
		#100000;
		err_count++;
		test_done();
	end
endmodule
